// file: hw/mppc_pkg.sv
package mppc_pkg;

  // ----------------------------------------------------------------
  // Port geometry
  // ----------------------------------------------------------------
  localparam int MPPC_NPORT = 9; // Ports A..H and J
  localparam int MPPC_PW = 8; // Bits per port register

  // Packed array of all pins, one byte per port
  typedef logic [MPPC_NPORT-1:0][MPPC_PW-1:0] mppc_port_arr_t;

  // ----------------------------------------------------------------
  // Port indices
  // ----------------------------------------------------------------
  localparam logic [3:0] MPPC_PORT_A = 4'h0;
  localparam logic [3:0] MPPC_PORT_B = 4'h1;
  localparam logic [3:0] MPPC_PORT_C = 4'h2;
  localparam logic [3:0] MPPC_PORT_D = 4'h3;
  localparam logic [3:0] MPPC_PORT_E = 4'h4;
  localparam logic [3:0] MPPC_PORT_F = 4'h5;
  localparam logic [3:0] MPPC_PORT_G = 4'h6;
  localparam logic [3:0] MPPC_PORT_H = 4'h7;
  localparam logic [3:0] MPPC_PORT_J = 4'h8;
  // First port that lives in the extended map
  localparam logic [3:0] MPPC_EXT_FIRST = MPPC_PORT_H;
  // Number of ports as an index-width value
  localparam logic [3:0] MPPC_NPORT_IDX = 4'h9;

  // Implemented bits per port (G has six, J has seven)
  localparam mppc_port_arr_t MPPC_PORT_MASK = {
    8'h7F, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF
  };

  // ----------------------------------------------------------------
  // Write selectors of the core write port
  // ----------------------------------------------------------------
  localparam logic MPPC_SEL_VAL = 1'b0; // Output-value / pull-up byte
  localparam logic MPPC_SEL_DIR = 1'b1; // Direction byte

  // ----------------------------------------------------------------
  // Scan pins on port F
  // ----------------------------------------------------------------
  localparam int MPPC_SCAN_TDI_BIT = 7;
  localparam int MPPC_SCAN_TDO_BIT = 6;
  localparam int MPPC_SCAN_TMS_BIT = 5;
  localparam int MPPC_SCAN_TCK_BIT = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  // Pull-ups of the scan input pins stay on through reset
  localparam logic [7:0] MPPC_F_PU_RST = 8'hB0;

endpackage : mppc_pkg

// file: hw/mppc_sync.sv
`timescale 1ns/10ps
`default_nettype none

module mppc_sync (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire mppc_pkg::mppc_port_arr_t i_pin,
  output logic [mppc_pkg::MPPC_NPORT-1:0][mppc_pkg::MPPC_PW-1:0] o_pin_sync
);
  import mppc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Two flip-flop stages per pin; stage one feeds stage two only
  typedef struct packed {
    mppc_port_arr_t s1; // First stage, may be metastable
    mppc_port_arr_t s2; // Second stage, safe to read
  } mppc_sync_st_t;

  mppc_sync_st_t st_q; // Registered state
  mppc_sync_st_t st_d; // Next state

  // Next-state logic: shift pin levels through both stages
  always_comb begin
    st_d = st_q;
    st_d.s1 = i_pin;
    st_d.s2 = st_q.s1;
  end

  // State register, cleared asynchronously
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Synchronised pin levels
  assign o_pin_sync = st_q.s2;

  // Pin level arrives after exactly two edges
  sync_delay_a: assert property (
    @(posedge i_mclk) disable iff (i_rst)
    (!i_rst)[*3] |-> o_pin_sync == $past(i_pin, 2)
  ) else $error("pin synchroniser delay is not two cycles");

endmodule : mppc_sync

`default_nettype wire

// file: hw/mppc_top.sv
// Operation
// - Ports A-F and H: eight bidirectional pins
// - Port G has six pins, bits 5-0
// - Port J has seven pins, bits 6-0
// - Every pin has its own pull-up enable
// - Reset tri-states all pins, clock not needed
// - Scan enabled: F7, F5, F4 pull-ups stay on
// - Port F feeds converter, else plain pins
// - Scan interface takes over its port F pins
// - Long enough reset pulse resets without clock
// - Enabled peripheral takes pin from general use
// - Extended-map ports refuse short I/O accesses
`timescale 1ns/10ps
`default_nettype none

module mppc_top (
  input wire logic i_mclk,
  input wire logic i_rst,
  // Core write port
  input wire logic i_wr,
  input wire logic [3:0] i_wr_port,
  input wire logic i_wr_sel,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_short,
  // Peripheral overrides
  input wire mppc_pkg::mppc_port_arr_t i_alt_en,
  input wire mppc_pkg::mppc_port_arr_t i_alt_oe,
  input wire mppc_pkg::mppc_port_arr_t i_alt_out,
  // Converter channel use on port F
  input wire logic [7:0] i_adc_sel,
  // Scan interface
  input wire logic i_scan_en,
  input wire logic i_scan_tdo,
  input wire logic i_scan_tdo_en,
  output logic o_scan_tck,
  output logic o_scan_tms,
  output logic o_scan_tdi,
  // Pins
  input wire mppc_pkg::mppc_port_arr_t i_pin_in,
  output mppc_pkg::mppc_port_arr_t o_pin_out,
  output mppc_pkg::mppc_port_arr_t o_pin_oe,
  output mppc_pkg::mppc_port_arr_t o_pin_pu,
  // Sampled pin levels and stored control bytes
  output mppc_pkg::mppc_port_arr_t o_pin_val,
  output mppc_pkg::mppc_port_arr_t o_val_rd,
  output mppc_pkg::mppc_port_arr_t o_dir_rd
);
  import mppc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // All module state in one record
  typedef struct packed {
    mppc_port_arr_t val; // Output value or pull-up select
    mppc_port_arr_t dir; // Direction, one drives
    mppc_port_arr_t pout; // Registered pin output level
    mppc_port_arr_t oe; // Registered pin output enable
    mppc_port_arr_t pu; // Registered pull-up enable
    mppc_port_arr_t pin; // Registered sampled pin level
    logic [2:0] scan; // Scan inputs {tdi, tms, tck}
  } mppc_top_st_t;

  mppc_top_st_t st_q; // Registered state
  mppc_top_st_t st_d; // Next state
  mppc_port_arr_t pin_sync; // Pins after two flip-flops
  logic wr_ok; // Write accepted this cycle

  // ----------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------
  mppc_sync u_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_pin(i_pin_in),
    .o_pin_sync(pin_sync)
  );

  // ----------------------------------------------------------------
  // Write qualification
  // ----------------------------------------------------------------
  // Index in range; short accesses to extended ports dropped
  always_comb begin
    wr_ok = i_wr && (i_wr_port < MPPC_NPORT_IDX);
    if (i_wr_short && (i_wr_port >= MPPC_EXT_FIRST)) begin
      wr_ok = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Control bytes, then per-pin drive, pull-up and sampling
  always_comb begin
    logic oe_v; // Pin enable for this bit
    logic out_v; // Pin level for this bit
    logic pu_v; // Pull-up for this bit
    logic ana_v; // Pin used by the converter
    oe_v = 1'b0;
    out_v = 1'b0;
    pu_v = 1'b0;
    ana_v = 1'b0;
    st_d = st_q;
    // Store the addressed byte, unimplemented bits held at zero
    if (wr_ok) begin
      if (i_wr_sel == MPPC_SEL_DIR) begin
        st_d.dir[i_wr_port] = i_wr_data & MPPC_PORT_MASK[i_wr_port];
      end else begin
        st_d.val[i_wr_port] = i_wr_data & MPPC_PORT_MASK[i_wr_port];
      end
    end
    // Every pin of every port; port F adds converter and scan overrides
    for (int p = 0; p < MPPC_NPORT; p++) begin
      for (int b = 0; b < MPPC_PW; b++) begin
        // General purpose: drive when direction set
        oe_v = st_q.dir[p][b];
        out_v = st_q.val[p][b];
        // Pull-up per bit: input with value bit set
        pu_v = ~st_q.dir[p][b] & st_q.val[p][b];
        ana_v = 1'b0;
        // Enabled peripheral owns the pin
        if (i_alt_en[p][b]) begin
          oe_v = i_alt_oe[p][b];
          out_v = i_alt_out[p][b];
          pu_v = 1'b0;
        end
        if (p == int'(MPPC_PORT_F)) begin
          // Converter channel: digital side released
          if (i_adc_sel[b]) begin
            oe_v = 1'b0;
            out_v = 1'b0;
            pu_v = 1'b0;
            ana_v = 1'b1;
          end
          // Scan interface owns its four pins
          if (i_scan_en) begin
            if (b == MPPC_SCAN_TDO_BIT) begin
              oe_v = i_scan_tdo_en;
              out_v = i_scan_tdo;
              pu_v = 1'b0;
            end else if (b == MPPC_SCAN_TDI_BIT ||
                         b == MPPC_SCAN_TMS_BIT ||
                         b == MPPC_SCAN_TCK_BIT) begin
              oe_v = 1'b0;
              out_v = 1'b0;
              pu_v = 1'b1;
              ana_v = 1'b0;
            end
          end
        end
        // Missing bits of G and J never drive or read
        st_d.oe[p][b] = oe_v & MPPC_PORT_MASK[p][b];
        st_d.pout[p][b] = out_v & MPPC_PORT_MASK[p][b];
        st_d.pu[p][b] = pu_v & MPPC_PORT_MASK[p][b];
        // Sampled level is readable whatever the direction
        st_d.pin[p][b] = pin_sync[p][b] & MPPC_PORT_MASK[p][b] &
                         ~ana_v;
      end
    end
    // Scan inputs pass on only while the interface is enabled
    if (i_scan_en) begin
      st_d.scan = {pin_sync[MPPC_PORT_F][MPPC_SCAN_TDI_BIT],
                   pin_sync[MPPC_PORT_F][MPPC_SCAN_TMS_BIT],
                   pin_sync[MPPC_PORT_F][MPPC_SCAN_TCK_BIT]};
    end else begin
      st_d.scan = 3'h0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset tri-states every pin at once, with or without a clock;
  // only the scan input pull-ups stay on
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= '0;
      st_q.pu[MPPC_PORT_F] <= MPPC_F_PU_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_pin_out = st_q.pout;
  assign o_pin_oe = st_q.oe;
  assign o_pin_pu = st_q.pu;
  assign o_pin_val = st_q.pin;
  assign o_val_rd = st_q.val;
  assign o_dir_rd = st_q.dir;
  assign o_scan_tdi = st_q.scan[2];
  assign o_scan_tms = st_q.scan[1];
  assign o_scan_tck = st_q.scan[0];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  // Direction write on port A, no peripheral
  sequence s_dir_wr_a;
    i_wr && i_wr_port == MPPC_PORT_A && i_wr_sel == MPPC_SEL_DIR &&
    !i_wr_short;
  endsequence

  sequence s_alt_off_a;
    i_alt_en[0] == '0;
  endsequence

  // Short access to an extended port
  sequence s_short_ext;
    i_wr && i_wr_short && i_wr_port == MPPC_PORT_H;
  endsequence

  // Written direction reaches the enables two edges later
  dir_to_drive_a: assert property (
    s_dir_wr_a ##1 s_alt_off_a |=> o_pin_oe[0] == $past(i_wr_data, 2)
  ) else $error("direction write did not reach output enable");

  // Pins come out of reset released
  reset_tristate_a: assert property (
    $fell(i_rst) |-> o_pin_oe == '0 && o_pin_out == '0
  ) else $error("pin driven on reset release");

  // Port G upper bits absent
  port_g_width_a: assert property (
    o_pin_oe[6][7:6] == 2'h0 && o_pin_pu[6][7:6] == 2'h0 &&
    o_pin_val[6][7:6] == 2'h0 && o_dir_rd[6][7:6] == 2'h0
  ) else $error("port G bits above five active");

  // Port J bit seven absent
  port_j_width_a: assert property (
    !o_pin_oe[8][7] && !o_pin_pu[8][7] && !o_pin_val[8][7] &&
    !o_val_rd[8][7]
  ) else $error("port J bit seven active");

  // Pull-up follows value with direction clear
  pull_select_a: assert property (
    !i_alt_en[1][2] |=>
      o_pin_pu[1][2] == $past(st_q.val[1][2] & ~st_q.dir[1][2])
  ) else $error("pull-up select wrong");

  // Short access leaves extended port bytes alone
  short_refused_a: assert property (
    s_short_ext |=> st_q.dir[7] == $past(st_q.dir[7]) &&
      st_q.val[7] == $past(st_q.val[7])
  ) else $error("short access changed an extended port");

  // Converter channel frees the digital pin
  adc_release_a: assert property (
    i_adc_sel[3] && !i_scan_en |=>
      !o_pin_oe[5][3] && !o_pin_pu[5][3] && !o_pin_val[5][3]
  ) else $error("converter pin still digital");

  // Scan input pull-ups on, pins released
  scan_pull_a: assert property (
    i_scan_en |=> o_pin_pu[5][7] && o_pin_pu[5][5] && o_pin_pu[5][4] &&
      !o_pin_oe[5][7] && !o_pin_oe[5][5] && !o_pin_oe[5][4]
  ) else $error("scan pull-ups not held");

  // Scan output drives its pin
  scan_tdo_a: assert property (
    i_scan_en && i_scan_tdo_en |=>
      o_pin_oe[5][6] && o_pin_out[5][6] == $past(i_scan_tdo)
  ) else $error("scan output not on its pin");

  // Peripheral value and enable pass to the pin
  alt_takeover_a: assert property (
    i_alt_en[1][0] |=> o_pin_out[1][0] == $past(i_alt_out[1][0]) &&
      o_pin_oe[1][0] == $past(i_alt_oe[1][0]) && !o_pin_pu[1][0]
  ) else $error("peripheral did not take the pin");

  // Scan data input level reaches o_scan_tdi three edges on
  scan_tdi_path_a: assert property (
    (i_scan_en && !i_rst)[*4] |->
      o_scan_tdi == $past(i_pin_in[MPPC_PORT_F][MPPC_SCAN_TDI_BIT], 3)
  ) else $error("scan data input level not passed on");

  // Scan outputs stay low while the interface is off
  scan_idle_a: assert property (
    !i_scan_en |=> !o_scan_tdi && !o_scan_tms && !o_scan_tck
  ) else $error("scan outputs active while interface off");

  // Value byte lands one edge after its write
  val_write_a: assert property (
    i_wr && i_wr_port == MPPC_PORT_B && i_wr_sel == MPPC_SEL_VAL |=>
      o_val_rd[1] == $past(i_wr_data)
  ) else $error("value write did not land");

  // Pin level readable three edges after it was seen
  sample_path_a: assert property (
    (!i_rst)[*4] |-> o_pin_val[0] == $past(i_pin_in[0], 3)
  ) else $error("sampled pin level wrong");

endmodule : mppc_top

`default_nettype wire

// file: sim/mppc_board.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Board circuitry on the pins
// ----------------------------------------------------------------
module mppc_board (
  input wire logic i_mclk,
  input wire mppc_pkg::mppc_port_arr_t i_out,
  input wire mppc_pkg::mppc_port_arr_t i_oe,
  input wire mppc_pkg::mppc_port_arr_t i_pu,
  input wire mppc_pkg::mppc_port_arr_t i_ext_en,
  input wire mppc_pkg::mppc_port_arr_t i_ext_val,
  output mppc_pkg::mppc_port_arr_t o_pin
);
  import mppc_pkg::*;

  mppc_port_arr_t float_q = '0; // Changing level of an undriven pin

  // Floating pins wander every cycle so a stale level never reads back
  always @(posedge i_mclk) begin
    float_q <= ~float_q;
  end

  // Device drive wins, then board drive, then pull-up, else floating
  always_comb begin
    o_pin = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext_val) |
      (~i_oe & ~i_ext_en & (i_pu | float_q));
  end
endmodule : mppc_board

`default_nettype wire

// file: sim/mppc_top_tb.sv
`timescale 1ns/10ps
`default_nettype none

module mppc_top_tb;
  import mppc_pkg::*;

  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic i_mclk, i_rst, i_wr, i_wr_sel, i_wr_short;
  logic i_scan_en, i_scan_tdo, i_scan_tdo_en;
  logic o_scan_tck, o_scan_tms, o_scan_tdi;
  logic [3:0] i_wr_port;
  logic [7:0] i_wr_data, i_adc_sel;
  mppc_port_arr_t i_alt_en, i_alt_oe, i_alt_out, ext_en, ext_val, pin;
  mppc_port_arr_t o_pin_out, o_pin_oe, o_pin_pu, o_pin_val, o_val_rd;
  mppc_port_arr_t o_dir_rd;
  int err_count = 0; // Mismatches seen
  int tests_run = 0; // Comparisons made

  mppc_top dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_wr(i_wr),
    .i_wr_port(i_wr_port), .i_wr_sel(i_wr_sel), .i_wr_data(i_wr_data),
    .i_wr_short(i_wr_short), .i_alt_en(i_alt_en), .i_alt_oe(i_alt_oe),
    .i_alt_out(i_alt_out), .i_adc_sel(i_adc_sel), .i_scan_en(i_scan_en),
    .i_scan_tdo(i_scan_tdo), .i_scan_tdo_en(i_scan_tdo_en),
    .o_scan_tck(o_scan_tck), .o_scan_tms(o_scan_tms),
    .o_scan_tdi(o_scan_tdi), .i_pin_in(pin), .o_pin_out(o_pin_out),
    .o_pin_oe(o_pin_oe), .o_pin_pu(o_pin_pu), .o_pin_val(o_pin_val),
    .o_val_rd(o_val_rd), .o_dir_rd(o_dir_rd));

  mppc_board board (.i_mclk(i_mclk), .i_out(o_pin_out), .i_oe(o_pin_oe),
    .i_pu(o_pin_pu), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pin(pin));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Compare one byte and count it
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  // One write pulse, then time for pins to settle
  task automatic wr(input logic [3:0] p, input logic s, input logic [7:0] d,
                    input logic sh);
    @(negedge i_mclk);
    i_wr = 1'b1;
    i_wr_port = p;
    i_wr_sel = s;
    i_wr_data = d;
    i_wr_short = sh;
    @(negedge i_mclk);
    i_wr = 1'b0;
    repeat (4) @(negedge i_mclk);
  endtask : wr

  // Asynchronous reset held three cycles, checked before any edge
  task automatic pulse_reset(input logic [7:0] f_pu);
    @(negedge i_mclk);
    i_rst = 1'b1;
    #2;
    for (int p = 0; p < MPPC_NPORT; p++) begin
      chk(o_pin_oe[p], 8'h00);
      chk(o_pin_pu[p], (p == 5) ? f_pu : 8'h00);
    end
    repeat (3) @(negedge i_mclk);
    i_rst = 1'b0;
    repeat (2) @(negedge i_mclk);
  endtask : pulse_reset

  // Every run ends here
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Widths, drive and readback of every port
  task automatic t_ports;
    for (int p = 0; p < MPPC_NPORT; p++) begin
      wr(p[3:0], MPPC_SEL_DIR, 8'hFF, 1'b0);
      wr(p[3:0], MPPC_SEL_VAL, 8'hA5, 1'b0);
      chk(o_dir_rd[p], MPPC_PORT_MASK[p]);
      chk(o_pin_oe[p], MPPC_PORT_MASK[p]);
      chk(o_pin_out[p], 8'hA5 & MPPC_PORT_MASK[p]);
      chk(o_pin_val[p], 8'hA5 & MPPC_PORT_MASK[p]);
    end
    $display("test ports done");
  endtask : t_ports

  // Mixed inputs and outputs with per-bit pull-ups
  task automatic t_pullup;
    for (int p = 0; p < MPPC_NPORT; p++) begin
      wr(p[3:0], MPPC_SEL_DIR, 8'h0F, 1'b0);
      wr(p[3:0], MPPC_SEL_VAL, 8'hF5, 1'b0);
      chk(o_pin_pu[p], 8'hF0 & MPPC_PORT_MASK[p]);
      chk(o_pin_val[p], 8'hF5 & MPPC_PORT_MASK[p]);
    end
    // Board drives port C inputs with pulls off
    wr(MPPC_PORT_C, MPPC_SEL_DIR, 8'h00, 1'b0);
    wr(MPPC_PORT_C, MPPC_SEL_VAL, 8'h00, 1'b0);
    ext_en[2] = 8'hFF;
    ext_val[2] = 8'h5A;
    repeat (4) @(negedge i_mclk);
    chk(o_pin_pu[2], 8'h00);
    chk(o_pin_val[2], 8'h5A);
    $display("test pullup done");
  endtask : t_pullup

  // Short accesses refused on the extended ports, bad index ignored
  task automatic t_short;
    wr(MPPC_PORT_A, MPPC_SEL_VAL, 8'h3C, 1'b1);
    chk(o_val_rd[0], 8'h3C);
    wr(MPPC_PORT_H, MPPC_SEL_VAL, 8'h3C, 1'b1);
    chk(o_val_rd[7], 8'hF5);
    wr(MPPC_PORT_J, MPPC_SEL_VAL, 8'h3C, 1'b1);
    chk(o_val_rd[8], 8'h75);
    wr(MPPC_PORT_H, MPPC_SEL_VAL, 8'h3C, 1'b0);
    chk(o_val_rd[7], 8'h3C);
    wr(MPPC_NPORT_IDX, MPPC_SEL_VAL, 8'h00, 1'b0);
    chk(o_val_rd[0], 8'h3C);
    $display("test short done");
  endtask : t_short

  // Converter and peripheral takeover
  task automatic t_share;
    i_adc_sel = 8'hFF;
    i_alt_en[1] = 8'hFF;
    i_alt_oe[1] = 8'hF0;
    i_alt_out[1] = 8'hC3;
    repeat (4) @(negedge i_mclk);
    chk(o_pin_oe[5], 8'h00);
    chk(o_pin_pu[5], 8'h00);
    chk(o_pin_val[5], 8'h00);
    chk(o_pin_oe[1], 8'hF0);
    chk(o_pin_out[1], 8'hC3);
    chk(o_pin_pu[1], 8'h00);
    i_adc_sel = 8'h00;
    i_alt_en[1] = 8'h00;
    repeat (2) @(negedge i_mclk);
    chk(o_pin_oe[5], 8'h0F);
    $display("test share done");
  endtask : t_share

  // Scan pins on port F, also through a reset
  task automatic t_scan;
    i_scan_en = 1'b1;
    i_scan_tdo = 1'b1;
    i_scan_tdo_en = 1'b1;
    ext_en[5] = 8'hB0;
    ext_val[5] = 8'hA0;
    repeat (5) @(negedge i_mclk);
    chk(o_pin_oe[5], 8'h4F);
    chk(o_pin_pu[5], 8'hB0);
    chk(o_pin_out[5] & 8'h40, 8'h40);
    chk({5'h00, o_scan_tdi, o_scan_tms, o_scan_tck}, 8'h06);
    pulse_reset(8'hB0);
    chk(o_pin_pu[5], 8'hB0);
    chk(o_pin_oe[5], 8'h40);
    i_scan_tdo_en = 1'b0;
    repeat (2) @(negedge i_mclk);
    chk(o_pin_oe[5], 8'h00);
    i_scan_en = 1'b0;
    repeat (2) @(negedge i_mclk);
    chk(o_pin_pu[5], 8'h00);
    $display("test scan done");
  endtask : t_scan

  // ----------------------------------------------------------------
  // Clock, main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end

  initial begin
    {i_wr, i_wr_sel, i_wr_short, i_scan_en, i_scan_tdo} = '0;
    i_scan_tdo_en = 1'b0;
    i_wr_port = 4'h0;
    i_wr_data = 8'h00;
    i_adc_sel = 8'h00;
    {i_alt_en, i_alt_oe, i_alt_out, ext_en, ext_val} = '0;
    i_rst = 1'b1;
    repeat (3) @(negedge i_mclk);
    i_rst = 1'b0;
    t_ports();
    t_pullup();
    t_short();
    t_share();
    t_scan();
    pulse_reset(8'hB0);
    final_report();
  end

  initial begin
    #100000;
    err_count++;
    final_report();
  end
endmodule : mppc_top_tb

`default_nettype wire
